// file: src/wwdt_params.svh
// constants for the windowed watchdog: offsets, fields, resets and timing
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define WWDT_ADR_CTRL0      8'h00
`define WWDT_ADR_CTRL1      8'h04
`define WWDT_ADR_PWR        8'h08
`define WWDT_ADR_ISTS       8'h0c
`define WWDT_ADR_IMASK      8'h10
`define WWDT_ADR_COUNT      8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WWDT_C0_EN          0
`define WWDT_C0_PS_LSB      1
`define WWDT_C0_PS_MSB      5
`define WWDT_C1_CS_LSB      0
`define WWDT_C1_CS_MSB      2
`define WWDT_C1_WIN_LSB     8
`define WWDT_C1_WIN_MSB     10
`define WWDT_PWR_BREACH     0
`define WWDT_PWR_RSTF       1
`define WWDT_PWR_EXPF       2
`define WWDT_PWR_PDF        3
`define WWDT_IRQ_TMO        0
`define WWDT_IRQ_VIOL       1
`define WWDT_IRQ_WAKE       2

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define WWDT_PS_RST         5'h0b
`define WWDT_SW_EN_RST      1'b0
`define WWDT_WIN_RST        3'h7
`define WWDT_CS_RST         3'h0
`define WWDT_PS_MAX         5'h12
`define WWDT_PS_BASE        5'h05
`define WWDT_WIN_FULL       3'h7
`define WWDT_CFG_DEFER      3'h7
`define WWDT_CS_MF          3'h1
`define WWDT_MODE_ON        2'h3
`define WWDT_MODE_AWAKE     2'h2
`define WWDT_MODE_SW        2'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WWDT_CLK_HZ         250000000
`define WWDT_LF_HZ          31000
`define WWDT_MF_HZ          31250

`endif

// file: src/wwdt_pkg.sv
// types shared by the windowed watchdog design
package wwdt_pkg;

	// time base source
	typedef enum logic {WWDT_SRC_LF, WWDT_SRC_MF} wwdt_src_e;

	// whole state of the watchdog block
	typedef struct packed {
		logic        sw_en;
		logic [4:0]  ps;
		logic [2:0]  win;
		logic [2:0]  cs;
		logic [23:0] cnt;
		logic [13:0] div;
		logic        armed;
		logic        sleep_d;
		logic        osf_s1;
		logic        osf_s2;
		logic        ost_s1;
		logic        ost_s2;
		logic        breach;
		logic        rstf;
		logic        expf;
		logic        pdf;
		logic [2:0]  ists;
		logic [2:0]  imask;
		logic        irq;
		logic        ack;
		logic [31:0] dat;
		logic        sys_rst;
		logic        wake;
	} wwdt_state_s;

endpackage : wwdt_pkg

// file: src/wwdt_top.sv
// windowed watchdog timer with wishbone register access
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "wwdt_params.svh"

// Summary of operation
// - reset the system when the count reaches the period without valid kick.
// - windowed mode accepts a kick only inside the open window; else violation.
// - time base is the 31 kHz or 31.25 kHz source, chosen by config or register.
// - enable config 11 keeps the watchdog running always, sleep included.
// - enable config 10 runs while awake, stops during sleep.
// - enable config 01 follows the software enable bit.
// - enable config 00 keeps the watchdog off always.
// - five-bit prescale picks 1 ms to 256 s, two seconds after reset.
// - window size from config field, or from register when config is 111.
// - window spans 12.5 to 100 percent of period; 100 means unrestricted.
// - violation resets the system and clears the breach flag; firmware sets it.
// - windowed kick needs a prior read of control zero; unarmed kick violates.
// - counter clears on reset, kick, sleep change, off, startup wait, control zero and one writes.
// - counter clears on sleep entry and wake, held clear during startup wait.
// - time-out during sleep wakes the device and updates status flags.
// - oscillator failure clears the counter; divider changes do not.
// - control zero: prescale at bits 5..1, enable at bit 0, 7..6 read zero.
// - prescale codes double 1:32 to 1:8388608; reserved codes act as 1:32.

module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int LF_DIV = `WWDT_CLK_HZ / `WWDT_LF_HZ,
	parameter int MF_DIV = `WWDT_CLK_HZ / `WWDT_MF_HZ
)(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// configuration word fields
	input  wire logic [1:0]  dog_enable_cfg_i,
	input  wire logic [2:0]  clk_src_cfg_i,
	input  wire logic [2:0]  window_size_cfg_i,
	// core and oscillator status
	input  wire logic        kick_instruction_i,
	input  wire logic        sleep_i,
	input  wire logic        osc_startup_wait_i,
	input  wire logic        osc_fail_i,
	// results
	output logic             sys_reset_o,
	output logic             wake_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	wwdt_state_s st_r;
	wwdt_state_s st_nxt;

	// decoded terms, shared by the next-state logic and the checks
	logic        acc;
	logic        wr0;
	logic        wr1;
	logic        wrp;
	logic        wri;
	logic        wrm;
	logic        rd0;
	logic        active;
	logic        tick;
	logic [13:0] div_lim;
	logic [4:0]  ps_eff;
	logic [23:0] period_m1;
	logic [23:0] open_at;
	logic [2:0]  win_eff;
	logic        windowed;
	logic        in_open;
	logic        kick;
	logic        kick_ok;
	logic        viol;
	logic        sleep_chg;
	logic        clr;
	logic        tmo;
	logic        tmo_wake;
	logic        tmo_sleep;
	wwdt_src_e   src;

	// ----------------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------------
	// writes land at the edge where the master sees ack
	always_comb
	begin
		acc = wb_cyc_i & wb_stb_i & st_r.ack;
		wr0 = acc & wb_we_i & (wb_adr_i == `WWDT_ADR_CTRL0);
		wr1 = acc & wb_we_i & (wb_adr_i == `WWDT_ADR_CTRL1);
		wrp = acc & wb_we_i & (wb_adr_i == `WWDT_ADR_PWR);
		wri = acc & wb_we_i & (wb_adr_i == `WWDT_ADR_ISTS);
		wrm = acc & wb_we_i & (wb_adr_i == `WWDT_ADR_IMASK);
		rd0 = acc & !wb_we_i & (wb_adr_i == `WWDT_ADR_CTRL0);
	end

	// ----------------------------------------------------------------------
	// mode, time base, period and window
	// ----------------------------------------------------------------------
	always_comb
	begin
		// enable mode from the config field, sleep and software bit
		case (dog_enable_cfg_i)
			`WWDT_MODE_ON:    active = 1'b1;
			`WWDT_MODE_AWAKE: active = !sleep_i;
			`WWDT_MODE_SW:    active = st_r.sw_en;
			default:          active = 1'b0;
		endcase
		// register select is only consulted when the config defers to it
		if (clk_src_cfg_i == `WWDT_CFG_DEFER)
			src = (st_r.cs == `WWDT_CS_MF) ? WWDT_SRC_MF : WWDT_SRC_LF;
		else
			src = (clk_src_cfg_i == `WWDT_CS_MF) ? WWDT_SRC_MF : WWDT_SRC_LF;
		// the oscillators are modelled as a divided system clock
		div_lim = (src == WWDT_SRC_MF) ? 14'(MF_DIV - 1) : 14'(LF_DIV - 1);
		// a switch to the faster source can leave the divider above its new limit,
		// so compare with at-or-above rather than wait for a full wrap
		tick    = (st_r.div >= div_lim);
		// reserved codes fall back to the shortest interval
		ps_eff    = (st_r.ps > `WWDT_PS_MAX) ? 5'h00 : st_r.ps;
		period_m1 = (24'h000001 << (`WWDT_PS_BASE + ps_eff)) - 24'h000001;
		// window of code plus one eighths of the period, code 7 means always open
		win_eff  = (window_size_cfg_i == `WWDT_CFG_DEFER) ? st_r.win
			: window_size_cfg_i;
		windowed = (win_eff != `WWDT_WIN_FULL);
		// open part sits at the end of the period
		open_at  = 24'(`WWDT_WIN_FULL - win_eff) << (5'h02 + ps_eff);
		in_open  = (st_r.cnt >= open_at);
	end

	// ----------------------------------------------------------------------
	// kick, clear and time-out decisions
	// ----------------------------------------------------------------------
	always_comb
	begin
		kick      = kick_instruction_i & active;
		// an unarmed or early kick in windowed mode is a violation
		kick_ok   = !windowed | (st_r.armed & in_open);
		viol      = kick & !kick_ok;
		sleep_chg = (sleep_i != st_r.sleep_d);
		// divider setting changes are not an input, so they cannot clear
		clr = !active | (kick & kick_ok) | sleep_chg | st_r.ost_s2 | st_r.osf_s2
			| wr0 | wr1 | viol;
		tmo       = active & tick & !clr & (st_r.cnt == period_m1);
		tmo_wake  = tmo & !sleep_i;
		tmo_sleep = tmo & sleep_i;
	end

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;

		// synchronisers for the asynchronous oscillator monitors
		st_nxt.osf_s1  = osc_fail_i;
		st_nxt.osf_s2  = st_r.osf_s1;
		st_nxt.ost_s1  = osc_startup_wait_i;
		st_nxt.ost_s2  = st_r.ost_s1;
		st_nxt.sleep_d = sleep_i;

		// free running time base divider
		st_nxt.div = tick ? 14'h0000 : st_r.div + 14'h0001;

		// watchdog counter
		if (clr || tmo)
			st_nxt.cnt = 24'h000000;
		else if (tick)
			st_nxt.cnt = st_r.cnt + 24'h000001;

		// arming: a read of control zero, used up by any kick
		if (kick_instruction_i)
			st_nxt.armed = 1'b0;
		else if (rd0)
			st_nxt.armed = 1'b1;

		// control registers, byte lanes honoured
		if (wr0 && wb_sel_i[0])
		begin
			st_nxt.sw_en = wb_dat_i[`WWDT_C0_EN];
			st_nxt.ps    = wb_dat_i[`WWDT_C0_PS_MSB:`WWDT_C0_PS_LSB];
		end
		if (wr1 && wb_sel_i[0])
			st_nxt.cs = wb_dat_i[`WWDT_C1_CS_MSB:`WWDT_C1_CS_LSB];
		if (wr1 && wb_sel_i[1])
			st_nxt.win = wb_dat_i[`WWDT_C1_WIN_MSB:`WWDT_C1_WIN_LSB];

		// power control flags: breach set by firmware, others cleared by a one
		if (wrp && wb_sel_i[0])
		begin
			if (wb_dat_i[`WWDT_PWR_BREACH])
				st_nxt.breach = 1'b1;
			if (wb_dat_i[`WWDT_PWR_RSTF])
				st_nxt.rstf = 1'b0;
			if (wb_dat_i[`WWDT_PWR_EXPF])
				st_nxt.expf = 1'b0;
			if (wb_dat_i[`WWDT_PWR_PDF])
				st_nxt.pdf = 1'b0;
		end
		// hardware events come after the writes so that they win
		if (sleep_i && !st_r.sleep_d)
			st_nxt.pdf = 1'b1;
		if (viol)
		begin
			st_nxt.breach = 1'b0;
			st_nxt.rstf   = 1'b1;
		end
		if (tmo)
		begin
			st_nxt.rstf = 1'b1;
			st_nxt.expf = 1'b1;
		end
		if (tmo_sleep)
			st_nxt.pdf = 1'b1;

		// reset request to the system, or a wake while asleep
		st_nxt.sys_rst = tmo_wake | viol;
		st_nxt.wake    = tmo_sleep;

		// interrupt status: write one to clear, new events win
		if (wri && wb_sel_i[0])
			st_nxt.ists = st_r.ists & ~wb_dat_i[2:0];
		if (tmo_wake)
			st_nxt.ists[`WWDT_IRQ_TMO] = 1'b1;
		if (viol)
			st_nxt.ists[`WWDT_IRQ_VIOL] = 1'b1;
		if (tmo_sleep)
			st_nxt.ists[`WWDT_IRQ_WAKE] = 1'b1;
		if (wrm && wb_sel_i[0])
			st_nxt.imask = wb_dat_i[2:0];
		st_nxt.irq = |(st_nxt.ists & st_nxt.imask);

		// one wait state, ack drops the cycle after it was given
		st_nxt.ack = wb_cyc_i & wb_stb_i & !st_r.ack;
		st_nxt.dat = 32'h00000000;
		if (wb_cyc_i && wb_stb_i && !st_r.ack && !wb_we_i)
		begin
			// unmapped offsets answer with zero
			if (wb_adr_i == `WWDT_ADR_CTRL0)
				st_nxt.dat = {26'h0000000, st_r.ps, st_r.sw_en};
			else if (wb_adr_i == `WWDT_ADR_CTRL1)
				st_nxt.dat = {21'h000000, st_r.win, 5'h00, st_r.cs};
			else if (wb_adr_i == `WWDT_ADR_PWR)
				st_nxt.dat = {28'h0000000, st_r.pdf, st_r.expf, st_r.rstf,
					st_r.breach};
			else if (wb_adr_i == `WWDT_ADR_ISTS)
				st_nxt.dat = {29'h00000000, st_r.ists};
			else if (wb_adr_i == `WWDT_ADR_IMASK)
				st_nxt.dat = {29'h00000000, st_r.imask};
			else if (wb_adr_i == `WWDT_ADR_COUNT)
				st_nxt.dat = {8'h00, st_r.cnt};
		end
	end

	// ----------------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------------
	// reset leaves breach set, as after power-up
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r        <= '0;
			st_r.sw_en  <= `WWDT_SW_EN_RST;
			st_r.ps     <= `WWDT_PS_RST;
			st_r.win    <= `WWDT_WIN_RST;
			st_r.cs     <= `WWDT_CS_RST;
			st_r.breach <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// outputs come straight from the state register
	assign wb_dat_o    = st_r.dat;
	assign wb_ack_o    = st_r.ack;
	assign sys_reset_o = st_r.sys_rst;
	assign wake_o      = st_r.wake;
	assign irq_o       = st_r.irq;

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_tmo_reset;
		active && !sleep_i && !clr && tick && st_r.cnt == period_m1 |=> sys_reset_o;
	endproperty
	a_tmo_reset: assert property (p_tmo_reset)
		else $error("time-out while awake gave no reset");

	property p_viol;
		kick_instruction_i && active && windowed && !st_r.armed
			|=> sys_reset_o && !st_r.breach && st_r.cnt == 24'h000000;
	endproperty
	a_viol: assert property (p_viol)
		else $error("unarmed windowed kick not treated as violation");

	property p_early;
		kick_instruction_i && active && windowed && st_r.cnt < open_at
			|=> sys_reset_o;
	endproperty
	a_early: assert property (p_early)
		else $error("kick before the window did not reset");

	property p_always_on;
		dog_enable_cfg_i == `WWDT_MODE_ON |-> active;
	endproperty
	a_always_on: assert property (p_always_on)
		else $error("always-on mode not active");

	property p_off_sleep;
		dog_enable_cfg_i == `WWDT_MODE_AWAKE && sleep_i |-> !active;
	endproperty
	a_off_sleep: assert property (p_off_sleep)
		else $error("awake-only mode active in sleep");

	property p_sw_mode;
		dog_enable_cfg_i == `WWDT_MODE_SW |-> active == st_r.sw_en;
	endproperty
	a_sw_mode: assert property (p_sw_mode)
		else $error("software mode does not follow enable bit");

	property p_off;
		dog_enable_cfg_i == 2'h0 [*2] |-> st_r.cnt == 24'h000000 && !sys_reset_o;
	endproperty
	a_off: assert property (p_off)
		else $error("disabled watchdog counted or reset");

	property p_wr_clear;
		wr0 || wr1 || st_r.osf_s2 |=> st_r.cnt == 24'h000000;
	endproperty
	a_wr_clear: assert property (p_wr_clear)
		else $error("counter not cleared by write or failure");

	property p_sleep_tmo;
		tmo && sleep_i |=> wake_o && !sys_reset_o && st_r.expf && st_r.pdf;
	endproperty
	a_sleep_tmo: assert property (p_sleep_tmo)
		else $error("time-out in sleep did not wake cleanly");

	property p_reserved;
		st_r.ps > `WWDT_PS_MAX |-> period_m1 == 24'h00001f;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved prescale not shortest period");

	property p_kick_clear;
		kick_instruction_i && active && (!windowed || (st_r.armed && st_r.cnt >= open_at))
			|=> st_r.cnt == 24'h000000 && !sys_reset_o;
	endproperty
	a_kick_clear: assert property (p_kick_clear)
		else $error("valid kick did not clear the counter quietly");

	property p_sleep_clear;
		sleep_i != st_r.sleep_d |=> st_r.cnt == 24'h000000;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear)
		else $error("sleep entry or wake did not clear the counter");

	property p_ost_hold;
		st_r.ost_s2 |=> st_r.cnt == 24'h000000;
	endproperty
	a_ost_hold: assert property (p_ost_hold)
		else $error("counter ran during the start-up wait");

	property p_disarm;
		kick_instruction_i |=> !st_r.armed;
	endproperty
	a_disarm: assert property (p_disarm)
		else $error("kick did not use up the arming read");

endmodule : wwdt_top

// file: dv/wwdt_core_model.sv
// behavioural core model: clear instruction, sleep level and oscillator status
`timescale 1ns/10ps

module wwdt_core_model (
	// clock and wake request
	input  wire logic clk_i,
	input  wire logic wake_i,
	// core status toward the watchdog
	output logic      kick_o,
	output logic      sleep_o,
	output logic      ost_o,
	output logic      osf_o
);
	// core starts awake, oscillator settled
	initial
	begin
		kick_o = 1'b0;
		sleep_o = 1'b0;
		ost_o = 1'b0;
		osf_o = 1'b0;
	end

	// a wake request ends sleep at the next edge, the core resumes
	always @(posedge clk_i)
		if (wake_i)
			sleep_o <= 1'b0;

	// one clear instruction, a single-cycle pulse
	task automatic kick();
		@(posedge clk_i);
		kick_o <= 1'b1;
		@(posedge clk_i);
		kick_o <= 1'b0;
	endtask : kick

	// enter or leave sleep
	task automatic set_sleep(input logic v);
		@(posedge clk_i);
		sleep_o <= v;
	endtask : set_sleep

	// start-up wait and failure levels, changed on an edge
	task automatic set_osc(input logic w, input logic f);
		@(posedge clk_i);
		ost_o <= w;
		osf_o <= f;
	endtask : set_osc
endmodule : wwdt_core_model

// file: dv/wwdt_tb_top.sv
// testbench for the windowed watchdog: registers, periods, window, modes, sleep
`timescale 1ns/10ps
`include "wwdt_params.svh"

module wwdt_tb_top;
	import wwdt_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        wb_ack_o, sys_reset_o, wake_o, irq_o;
	logic [1:0]  dog_enable_cfg_i;
	logic [2:0]  clk_src_cfg_i, window_size_cfg_i;
	logic        kick_w, sleep_w, ost_w, osf_w;
	int          bad_count, total_checks, cyc_cnt, n;
	logic [1:0]  ev;
	// mode table: {mode, sw enable, sleep, expected {wake, reset}}
	logic [5:0]  mt [8] = '{6'b110110, 6'b100001, 6'b100100, 6'b011001,
		6'b010000, 6'b001000, 6'b001100, 6'b110001};
	// source table: {cfg, CTRL1 source, cycles per tick}
	logic [8:0]  st [4] = '{{3'h1, 3'h0, 3'h3}, {3'h7, 3'h1, 3'h3},
		{3'h7, 3'h0, 3'h4}, {3'h2, 3'h1, 3'h4}};

	// ----------------------------------------------------------------
	// design and core model; dividers shortened to 4 and 3 cycles
	// ----------------------------------------------------------------
	wwdt_top #(.LF_DIV(4), .MF_DIV(3)) u_wwdt_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dog_enable_cfg_i(dog_enable_cfg_i),
		.clk_src_cfg_i(clk_src_cfg_i), .window_size_cfg_i(window_size_cfg_i),
		.kick_instruction_i(kick_w), .sleep_i(sleep_w), .osc_startup_wait_i(ost_w),
		.osc_fail_i(osf_w), .sys_reset_o(sys_reset_o), .wake_o(wake_o), .irq_o(irq_o));
	wwdt_core_model u_wwdt_core_model (.clk_i(clk_i), .wake_i(wake_o), .kick_o(kick_w),
		.sleep_o(sleep_w), .ost_o(ost_w), .osf_o(osf_w));

	// 250 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one classic wishbone cycle; ack wait is bounded so a dead slave cannot hang
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check(k < 20, 1'b1);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(q & m, e);
	endtask : rd

	// wait for a reset or wake pulse; a period window of 0 skips the timing check
	task automatic expect_out(input int lim, input logic [1:0] e, input int t);
		n = 0;
		ev = 2'b00;
		while (ev == 2'b00 && n < lim)
		begin
			@(posedge clk_i);
			n++;
			ev = {wake_o, sys_reset_o};
		end
		check(ev, e);
		if (t > 0)
			check(n >= t - 8 && n <= t + 8, 1'b1);
	endtask : expect_out

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			bad_count++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		dog_enable_cfg_i = 2'h3;
		clk_src_cfg_i = 3'h0;
		window_size_cfg_i = 3'h7;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`WWDT_ADR_CTRL0, 32'h16);
		rd(`WWDT_ADR_CTRL1, 32'h700);
		rd(`WWDT_ADR_PWR, 32'h1);
		rd(`WWDT_ADR_ISTS, 32'h0);
		rd(8'h18, 32'h0);
		wr(`WWDT_ADR_CTRL0, 32'hff);
		rd(`WWDT_ADR_CTRL0, 32'h3f);
		wb_sel_i <= 4'h0;
		wr(`WWDT_ADR_CTRL0, 32'h0);
		wb_sel_i <= 4'hf;
		rd(`WWDT_ADR_CTRL0, 32'h3f);
		$display("test registers done");
		// prescale codes, reserved code acts as the shortest
		wr(`WWDT_ADR_CTRL0, 32'h0);
		expect_out(300, 2'b01, 128);
		wr(`WWDT_ADR_CTRL0, 32'h2);
		expect_out(300, 2'b01, 256);
		wr(`WWDT_ADR_CTRL0, 32'h26);
		expect_out(300, 2'b01, 128);
		foreach (st[i])
		begin
			clk_src_cfg_i <= st[i][8:6];
			wr(`WWDT_ADR_CTRL1, {21'h0, 3'h7, 5'h0, st[i][5:3]});
			wr(`WWDT_ADR_CTRL0, 32'h0);
			expect_out(300, 2'b01, 32 * st[i][2:0]);
		end
		$display("test periods done");
		// flags and interrupt, watchdog off so no stray expiry
		dog_enable_cfg_i <= 2'h0;
		rd(`WWDT_ADR_PWR, 32'h7);
		rd(`WWDT_ADR_COUNT, 32'h0);
		rd(`WWDT_ADR_ISTS, 32'h1);
		check(irq_o, 1'b0);
		wr(`WWDT_ADR_IMASK, 32'h1);
		repeat (2) @(posedge clk_i);
		check(irq_o, 1'b1);
		wr(`WWDT_ADR_ISTS, 32'h1);
		repeat (2) @(posedge clk_i);
		check(irq_o, 1'b0);
		rd(`WWDT_ADR_ISTS, 32'h0);
		wr(`WWDT_ADR_PWR, 32'he);
		rd(`WWDT_ADR_PWR, 32'h1);
		$display("test interrupt done");
		// window: early armed, late unarmed, armed inside, narrowest window
		dog_enable_cfg_i <= 2'h3;
		window_size_cfg_i <= 3'h3;
		wr(`WWDT_ADR_CTRL0, 32'h0);
		rd(`WWDT_ADR_CTRL0, 32'h0);
		u_wwdt_core_model.kick();
		expect_out(4, 2'b01, 0);
		rd(`WWDT_ADR_PWR, 32'h2, 32'h3);
		rd(`WWDT_ADR_ISTS, 32'h2, 32'h2);
		wr(`WWDT_ADR_PWR, 32'h1);
		rd(`WWDT_ADR_PWR, 32'h1, 32'h1);
		wr(`WWDT_ADR_CTRL0, 32'h0);
		repeat (80) @(posedge clk_i);
		u_wwdt_core_model.kick();
		expect_out(4, 2'b01, 0);
		wr(`WWDT_ADR_CTRL0, 32'h0);
		repeat (80) @(posedge clk_i);
		rd(`WWDT_ADR_CTRL0, 32'h0);
		u_wwdt_core_model.kick();
		expect_out(200, 2'b01, 128);
		window_size_cfg_i <= 3'h0;
		wr(`WWDT_ADR_CTRL0, 32'h0);
		repeat (80) @(posedge clk_i);
		rd(`WWDT_ADR_CTRL0, 32'h0);
		u_wwdt_core_model.kick();
		expect_out(4, 2'b01, 0);
		window_size_cfg_i <= 3'h7;
		wr(`WWDT_ADR_CTRL1, 32'h300);
		wr(`WWDT_ADR_CTRL0, 32'h0);
		rd(`WWDT_ADR_CTRL0, 32'h0);
		u_wwdt_core_model.kick();
		expect_out(4, 2'b01, 0);
		wr(`WWDT_ADR_CTRL1, 32'h700);
		wr(`WWDT_ADR_CTRL0, 32'h0);
		u_wwdt_core_model.kick();
		expect_out(200, 2'b01, 128);
		$display("test window done");
		// enable modes against sleep and software enable
		foreach (mt[i])
		begin
			dog_enable_cfg_i <= mt[i][5:4];
			u_wwdt_core_model.set_sleep(mt[i][2]);
			wr(`WWDT_ADR_CTRL0, {31'h0, mt[i][3]});
			expect_out(200, mt[i][1:0], mt[i][1:0] != 2'b00 ? 128 : 0);
			if (mt[i][1])
			begin
				rd(`WWDT_ADR_PWR, 32'hc, 32'hc);
				rd(`WWDT_ADR_ISTS, 32'h4, 32'h4);
			end
		end
		$display("test modes done");
		// start-up wait and oscillator failure hold the count clear
		for (int k = 0; k < 2; k++)
		begin
			wr(`WWDT_ADR_CTRL0, 32'h0);
			u_wwdt_core_model.set_osc(k == 0, k == 1);
			expect_out(200, 2'b00, 0);
			u_wwdt_core_model.set_osc(1'b0, 1'b0);
			expect_out(200, 2'b01, 128);
		end
		$display("test oscillator done");
		results();
	end
endmodule : wwdt_tb_top
